// File: verilog/dmrb_register_bank.sv
// Miscellaneous display register bank: identifier, frame and underrun counters,
// host link width, variable refresh, stretched line limit, fractional pixel clock, pixel width.
// Assumes a simple synchronous register port from the host link decoder, and
// frame and underrun event pulses from the display pipeline on the same clock.
`timescale 1ns/1ps
// What this block does
// RULE1: Frame counter clears on reset, counts each displayed frame, wraps.
// RULE2: Fixed 8-bit identifier in low byte at offset zero, upper bits zero.
// RULE3: Host reads identifier after boot to confirm family and working mode.
// RULE4: Link width field: 00 single, 01 dual, 10 quad, 11 undefined.
// RULE5: Bit 2 set adds one dummy byte to every serial read.
// RULE6: Variable refresh enable, reset one, lowers rate during complex drawing.
// RULE7: Underrun counter resets to zero, counts every underrun line.
// RULE8: Software samples underrun counter per frame swap to detect underruns.
// RULE9: 12-bit stretched line maximum; zero disables; resets to zero.
// RULE10: Software sets stretched line maximum above the total line cycles.
// RULE11: Fractional clock: frequency bits 9..0, range 11..10, used in external sync.
// RULE12: Bit 0 selects one or two output pixels per pixel clock.
// RULE13: In two-pixel mode software loads even horizontal timing values.
// RULE14: Reserved bits read zero and ignore writes.
module dmrb_register_bank
	import dmrb_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = dmrb_pkg::CHIP_ID_DEFAULT
) (
	input  wire logic                          core_clk_in,
	input  wire logic                          reset_in,
	input  wire logic                          reg_wr_en_in,
	input  wire logic                          reg_rd_en_in,
	input  wire logic [dmrb_pkg::ADDR_W-1:0]   reg_addr_in,
	input  wire logic [dmrb_pkg::DATA_W-1:0]   reg_wr_data_in,
	input  wire logic                          frame_done_in,
	input  wire logic                          line_underrun_in,
	input  wire logic                          complex_drawing_in,
	input  wire logic [7:0]                    pixel_clock_div_in,
	output logic [dmrb_pkg::DATA_W-1:0]        reg_rd_data_out,
	output logic                               reg_rd_valid_out,
	output logic [1:0]                         link_width_out,
	output logic                               link_width_undefined_out,
	output logic                               extra_dummy_byte_out,
	output logic                               variable_refresh_en_out,
	output logic                               reduce_frame_rate_out,
	output logic [11:0]                        stretched_line_max_out,
	output logic                               stretched_line_en_out,
	output logic [9:0]                         frac_pclk_freq_out,
	output logic [1:0]                         frac_pclk_range_out,
	output logic                               frac_pclk_active_out,
	output logic                               two_pixels_per_clock_out,
	output logic [31:0]                        frame_count_out,
	output logic [31:0]                        underrun_count_out
);
	import dmrb_pkg::*;

	typedef struct packed {
		logic [31:0] rd_data;
		logic        rd_valid;
		logic [1:0]  link_width;
		logic        extra_dummy;
		logic        var_refresh;
		logic        reduce_rate;
		logic [11:0] line_max;
		logic [11:0] frac_cfg;
		logic        frac_active;
		logic        two_pixels;
		logic        width_undef;
		logic        line_en;
	} dmrb_state_t;

	dmrb_state_t state_q;
	dmrb_state_t state_d;
	logic [31:0] frame_count;
	logic [31:0] underrun_count;

	dmrb_event_counter #(
		.WIDTH (32)
	) u_frame_counter (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.event_in    (frame_done_in), // RULE1
		.count_out   (frame_count)
	);

	dmrb_event_counter #(
		.WIDTH (32)
	) u_underrun_counter (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.event_in    (line_underrun_in), // RULE7
		.count_out   (underrun_count)
	);

	always_comb begin
		state_d = state_q;
		state_d.rd_valid = reg_rd_en_in;

		// Writes: only the documented field bits are stored, the rest is dropped
		if (reg_wr_en_in) begin
			case (reg_addr_in)
				OFS_HOST_LINK_WIDTH: begin
					state_d.link_width  = reg_wr_data_in[LINK_WIDTH_LSB +: LINK_WIDTH_W]; // RULE4
					state_d.extra_dummy = reg_wr_data_in[EXTRA_DUMMY_BIT]; // RULE5
				end
				OFS_VARIABLE_REFRESH: begin
					state_d.var_refresh = reg_wr_data_in[0]; // RULE6
				end
				OFS_STRETCHED_LINE_MAX: begin
					state_d.line_max = reg_wr_data_in[LINE_MAX_W-1:0]; // RULE9
				end
				OFS_FRACTIONAL_PCLK_CFG: begin
					state_d.frac_cfg = reg_wr_data_in[FRAC_RANGE_LSB+FRAC_RANGE_W-1:0]; // RULE11
				end
				OFS_PIXELS_PER_CLOCK: begin
					state_d.two_pixels = reg_wr_data_in[0]; // RULE12
				end
				default: begin
				end
			endcase
		end

		// Reads: unmapped offsets and reserved bits return zero
		state_d.rd_data = 32'h0000_0000; // RULE14
		if (reg_rd_en_in) begin
			case (reg_addr_in)
				OFS_CHIP_IDENTIFIER: begin
					state_d.rd_data = {24'h00_0000, CHIP_ID}; // RULE2
				end
				OFS_FRAME_COUNTER: begin
					state_d.rd_data = frame_count; // RULE1
				end
				OFS_HOST_LINK_WIDTH: begin
					state_d.rd_data = {29'h0000_0000, state_q.extra_dummy, state_q.link_width};
				end
				OFS_VARIABLE_REFRESH: begin
					state_d.rd_data = {31'h0000_0000, state_q.var_refresh};
				end
				OFS_LINE_UNDERRUN_COUNT: begin
					state_d.rd_data = underrun_count; // RULE7
				end
				OFS_STRETCHED_LINE_MAX: begin
					state_d.rd_data = {20'h0_0000, state_q.line_max};
				end
				OFS_FRACTIONAL_PCLK_CFG: begin
					state_d.rd_data = {20'h0_0000, state_q.frac_cfg};
				end
				OFS_PIXELS_PER_CLOCK: begin
					state_d.rd_data = {31'h0000_0000, state_q.two_pixels};
				end
				default: begin
					state_d.rd_data = 32'h0000_0000;
				end
			endcase
		end

		// Frame rate is only lowered while enabled; disabled keeps a fixed rate
		state_d.reduce_rate = state_q.var_refresh & complex_drawing_in; // RULE6
		// Fractional settings take effect only in external sync mode
		state_d.frac_active = (pixel_clock_div_in == PIXEL_CLOCK_DIV_EXTERNAL_SYNC_MODE); // RULE11
		// Decoded from the next value so the flags line up with their registered fields
		state_d.width_undef = (state_d.link_width == DMRB_LINK_UNDEF); // RULE4
		state_d.line_en     = (state_d.line_max != LINE_MAX_RESET); // RULE9
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q.rd_data     <= 32'h0000_0000;
			state_q.rd_valid    <= 1'b0;
			state_q.link_width  <= LINK_WIDTH_RESET;
			state_q.extra_dummy <= EXTRA_DUMMY_RESET;
			state_q.var_refresh <= VARIABLE_REFRESH_RESET;
			state_q.reduce_rate <= 1'b0;
			state_q.line_max    <= LINE_MAX_RESET;
			state_q.frac_cfg    <= FRAC_PCLK_RESET;
			state_q.frac_active <= 1'b0;
			state_q.two_pixels  <= PIXELS_PER_CLOCK_RESET;
			state_q.width_undef <= 1'b0;
			state_q.line_en     <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign reg_rd_data_out          = state_q.rd_data;
	assign reg_rd_valid_out         = state_q.rd_valid;
	assign link_width_out           = state_q.link_width; // RULE4
	// Value 11 is flagged so the link logic can hold its current mode
	assign link_width_undefined_out = state_q.width_undef; // RULE4
	assign extra_dummy_byte_out     = state_q.extra_dummy; // RULE5
	assign variable_refresh_en_out  = state_q.var_refresh;
	assign reduce_frame_rate_out    = state_q.reduce_rate;
	assign stretched_line_max_out   = state_q.line_max;
	assign stretched_line_en_out    = state_q.line_en; // RULE9
	assign frac_pclk_freq_out       = state_q.frac_cfg[FRAC_FREQ_LSB +: FRAC_FREQ_W];
	assign frac_pclk_range_out      = state_q.frac_cfg[FRAC_RANGE_LSB +: FRAC_RANGE_W];
	assign frac_pclk_active_out     = state_q.frac_active;
	assign two_pixels_per_clock_out = state_q.two_pixels; // RULE12
	assign frame_count_out          = frame_count;
	assign underrun_count_out       = underrun_count;
endmodule

// File: verilog/dmrb_pkg.sv
// Package for the display miscellaneous register bank: offsets, field layouts, reset values.
// Assumes a byte-addressed register port with 32-bit data words.
package dmrb_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;

	localparam logic [15:0] OFS_CHIP_IDENTIFIER       = 16'h0000;
	localparam logic [15:0] OFS_FRAME_COUNTER         = 16'h0004;
	localparam logic [15:0] OFS_HOST_LINK_WIDTH       = 16'h0188;
	localparam logic [15:0] OFS_VARIABLE_REFRESH      = 16'h057c;
	localparam logic [15:0] OFS_LINE_UNDERRUN_COUNT   = 16'h060c;
	localparam logic [15:0] OFS_STRETCHED_LINE_MAX    = 16'h0610;
	localparam logic [15:0] OFS_FRACTIONAL_PCLK_CFG   = 16'h0614;
	localparam logic [15:0] OFS_PIXELS_PER_CLOCK      = 16'h0618;

	// Identifier value is arbitrary; set per product
	localparam logic [7:0]  CHIP_ID_DEFAULT           = 8'h5a;

	localparam int unsigned LINK_WIDTH_LSB            = 0;
	localparam int unsigned LINK_WIDTH_W              = 2;
	localparam int unsigned EXTRA_DUMMY_BIT           = 2;
	localparam int unsigned FRAC_FREQ_LSB             = 0;
	localparam int unsigned FRAC_FREQ_W               = 10;
	localparam int unsigned FRAC_RANGE_LSB            = 10;
	localparam int unsigned FRAC_RANGE_W              = 2;
	localparam int unsigned LINE_MAX_W                = 12;

	localparam logic [31:0] FRAME_COUNTER_RESET       = 32'h0000_0000;
	localparam logic [31:0] UNDERRUN_COUNTER_RESET    = 32'h0000_0000;
	localparam logic [1:0]  LINK_WIDTH_RESET          = 2'h0;
	localparam logic        EXTRA_DUMMY_RESET         = 1'b0;
	localparam logic        VARIABLE_REFRESH_RESET    = 1'b1;
	localparam logic [11:0] LINE_MAX_RESET            = 12'h000;
	localparam logic [11:0] FRAC_PCLK_RESET           = 12'h8a1;
	localparam logic        PIXELS_PER_CLOCK_RESET    = 1'b0;

	typedef enum logic [1:0] {
		DMRB_LINK_SINGLE = 2'h0,
		DMRB_LINK_DUAL   = 2'h1,
		DMRB_LINK_QUAD   = 2'h2,
		DMRB_LINK_UNDEF  = 2'h3
	} dmrb_link_width_t;

	localparam logic [7:0]  PIXEL_CLOCK_DIV_EXTERNAL_SYNC_MODE   = 8'h01;
endpackage

// File: verilog/dmrb_event_counter.sv
// Wrapping 32-bit event counter with synchronous clear.
// Assumes the event pulse is on the same clock as the counter.
`timescale 1ns/1ps
module dmrb_event_counter #(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic             core_clk_in,
	input  wire logic             reset_in,
	input  wire logic             event_in,
	output logic [WIDTH-1:0]      count_out
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
	} dmrb_cnt_state_t;

	dmrb_cnt_state_t state_q;
	dmrb_cnt_state_t state_d;

	always_comb begin
		state_d = state_q;
		// Natural overflow gives the wrap
		if (event_in) begin
			state_d.count = state_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign count_out = state_q.count;
endmodule

// File: tb/dmrb_register_bank_checker.sv
// Assertions on the display register bank ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module dmrb_register_bank_checker
	import dmrb_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = 8'h00
) (
	input wire logic                        core_clk_in,
	input wire logic                        reset_in,
	input wire logic                        reg_wr_en_in,
	input wire logic                        reg_rd_en_in,
	input wire logic [dmrb_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [dmrb_pkg::DATA_W-1:0] reg_wr_data_in,
	input wire logic                        frame_done_in,
	input wire logic                        line_underrun_in,
	input wire logic                        complex_drawing_in,
	input wire logic [7:0]                  pixel_clock_div_in,
	input wire logic [dmrb_pkg::DATA_W-1:0] reg_rd_data_out,
	input wire logic                        reg_rd_valid_out,
	input wire logic [1:0]                  link_width_out,
	input wire logic                        link_width_undefined_out,
	input wire logic                        variable_refresh_en_out,
	input wire logic                        reduce_frame_rate_out,
	input wire logic [11:0]                 stretched_line_max_out,
	input wire logic                        stretched_line_en_out,
	input wire logic                        frac_pclk_active_out,
	input wire logic                        two_pixels_per_clock_out,
	input wire logic [31:0]                 frame_count_out,
	input wire logic [31:0]                 underrun_count_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	property p_frame_step; frame_done_in |=> frame_count_out == $past(frame_count_out) + 32'h1; endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame count did not step");
	property p_frame_hold; !frame_done_in |=> $stable(frame_count_out); endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame count moved without a frame");
	property p_under_step; line_underrun_in |=> underrun_count_out == $past(underrun_count_out) + 32'h1; endproperty
	a_under_step: assert property (p_under_step) else $error("underrun count did not step");
	property p_id_read;
		reg_rd_en_in && reg_addr_in == OFS_CHIP_IDENTIFIER |=> reg_rd_valid_out && reg_rd_data_out == {24'h0, CHIP_ID};
	endproperty
	a_id_read: assert property (p_id_read) else $error("identifier read wrong");
	property p_undef; link_width_undefined_out == (link_width_out == 2'h3); endproperty
	a_undef: assert property (p_undef) else $error("undefined width flag wrong");
	property p_reduce;
		$past(!reset_in) && variable_refresh_en_out && $past(variable_refresh_en_out)
			|-> reduce_frame_rate_out == $past(complex_drawing_in);
	endproperty
	a_reduce: assert property (p_reduce) else $error("frame rate reduction wrong");
	property p_stretch; stretched_line_en_out == (stretched_line_max_out != 12'h000); endproperty
	a_stretch: assert property (p_stretch) else $error("stretched line enable wrong");
	property p_frac;
		$past(!reset_in) |-> frac_pclk_active_out == $past(pixel_clock_div_in == PIXEL_CLOCK_DIV_EXTERNAL_SYNC_MODE);
	endproperty
	a_frac: assert property (p_frac) else $error("external sync detect wrong");
	property p_ppc;
		reg_wr_en_in && reg_addr_in == OFS_PIXELS_PER_CLOCK |=> two_pixels_per_clock_out == $past(reg_wr_data_in[0]);
	endproperty
	a_ppc: assert property (p_ppc) else $error("pixel width select wrong");
	property p_rd_idle; !reg_rd_en_in |=> !reg_rd_valid_out && reg_rd_data_out == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read port not idle");
endmodule
bind dmrb_register_bank dmrb_register_bank_checker #(.CHIP_ID(CHIP_ID)) u_dmrb_register_bank_checker (
	.core_clk_in, .reset_in, .reg_wr_en_in, .reg_rd_en_in, .reg_addr_in, .reg_wr_data_in, .frame_done_in,
	.line_underrun_in, .complex_drawing_in, .pixel_clock_div_in, .reg_rd_data_out, .reg_rd_valid_out,
	.link_width_out, .link_width_undefined_out, .variable_refresh_en_out, .reduce_frame_rate_out,
	.stretched_line_max_out, .stretched_line_en_out, .frac_pclk_active_out, .two_pixels_per_clock_out,
	.frame_count_out, .underrun_count_out);

// File: tb/dmrb_pipe_model.sv
// Display pipeline stand-in: emits a burst of frame and underrun pulses.
// Assumes the bench loads a burst length; pulses are one cycle with a gap between.
`timescale 1ns/1ps
module dmrb_pipe_model (
	input  wire logic       core_clk_in,
	input  wire logic       load_in,
	input  wire logic [7:0] n_in,
	input  wire logic       under_en_in,
	output logic            frame_done_out,
	output logic            line_underrun_out
);
	logic [8:0] left_q = 9'h000;
	// Updates just after the rising edge; load is driven between edges so it is seen once
	always @(posedge core_clk_in) begin
		if (load_in) begin
			left_q <= {n_in, 1'b0};
		end else if (left_q != 9'h000) begin
			left_q <= left_q - 9'h001;
		end
	end
	assign frame_done_out    = left_q[0];
	assign line_underrun_out = left_q[0] & under_en_in;
endmodule

// File: tb/display_misc_register_bank_bench.sv
// Self-checking bench for the display register bank.
// Assumes the register port contract: one-cycle strobes, read answer one cycle later.
`timescale 1ns/1ps
module display_misc_register_bank_bench;
	import dmrb_pkg::*;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
	logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, complex = 0, load = 0, under_en = 0;
	logic [15:0] addr = 0;
	logic [31:0] wdata = 0, rdata, fcnt, ucnt;
	logic [7:0] pdiv = 8'h02, n = 0;
	logic rvalid, undef, dummy, ven, reduce, sen, factive, two, fdone, lund;
	logic [1:0] lw, frange;
	logic [11:0] smax;
	logic [9:0] ffreq;
	int err_total = 0, num_checks = 0;
	logic [15:0] ofs [9] = '{16'h0, 16'h4, 16'h188, 16'h57c, 16'h60c, 16'h610, 16'h614, 16'h618, 16'h100};
	logic [31:0] rst_v [9] = '{{24'h0, ID}, 0, 0, 1, 0, 0, 32'h8a1, 0, 0};
	logic [31:0] one_v [9] = '{{24'h0, ID}, 0, 7, 1, 0, 32'hfff, 32'hfff, 1, 0};
	always #5 clk = ~clk;
	dmrb_pipe_model u_dmrb_pipe_model (.core_clk_in(clk), .load_in(load), .n_in(n), .under_en_in(under_en),
		.frame_done_out(fdone), .line_underrun_out(lund));
	dmrb_register_bank #(.CHIP_ID(ID)) u_dmrb_register_bank (.core_clk_in(clk), .reset_in(rst),
		.reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wr_data_in(wdata),
		.frame_done_in(fdone), .line_underrun_in(lund), .complex_drawing_in(complex),
		.pixel_clock_div_in(pdiv), .reg_rd_data_out(rdata), .reg_rd_valid_out(rvalid), .link_width_out(lw),
		.link_width_undefined_out(undef), .extra_dummy_byte_out(dummy), .variable_refresh_en_out(ven),
		.reduce_frame_rate_out(reduce), .stretched_line_max_out(smax), .stretched_line_en_out(sen),
		.frac_pclk_freq_out(ffreq), .frac_pclk_range_out(frange), .frac_pclk_active_out(factive),
		.two_pixels_per_clock_out(two), .frame_count_out(fcnt), .underrun_count_out(ucnt));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk); wr_en = 1; addr = a; wdata = d;
		@(negedge clk); wr_en = 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(negedge clk); rd_en = 1; addr = a;
		@(negedge clk); rd_en = 0;
		chk({31'h0, rvalid}, 1);
		chk(rdata, exp);
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic complete_run;
		if (err_total == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
	initial begin
		settle(4); rst = 0;
		rd(OFS_CHIP_IDENTIFIER, {24'h0, ID});
		for (int i = 0; i < 9; i++) rd(ofs[i], rst_v[i]);
		for (int i = 0; i < 9; i++) wr(ofs[i], 32'hffff_ffff);
		for (int i = 0; i < 9; i++) rd(ofs[i], one_v[i]);
		for (int k = 0; k < 8; k++) begin
			wr(OFS_HOST_LINK_WIDTH, k);
			chk({29'h0, dummy, lw}, k);
			chk({31'h0, undef}, (k % 4) == 3);
		end
		wr(OFS_STRETCHED_LINE_MAX, 32'h0000_0800);
		chk({19'h0, sen, smax}, 32'h1800);
		wr(OFS_STRETCHED_LINE_MAX, 0);
		chk({31'h0, sen}, 0);
		wr(OFS_FRACTIONAL_PCLK_CFG, 32'hffff_f6a5);
		chk({20'h0, frange, ffreq}, 32'h6a5);
		pdiv = 8'h01; settle(2); chk({31'h0, factive}, 1);
		pdiv = 8'h02; settle(2); chk({31'h0, factive}, 0);
		complex = 1;
		for (int e = 0; e < 2; e++) begin
			wr(OFS_VARIABLE_REFRESH, e); settle(2);
			chk({30'h0, ven, reduce}, {30'h0, e[0], e[0]});
		end
		complex = 0; settle(2); chk({31'h0, reduce}, 0);
		wr(OFS_PIXELS_PER_CLOCK, 1); chk({31'h0, two}, 1);
		wr(OFS_PIXELS_PER_CLOCK, 0); chk({31'h0, two}, 0);
		n = 5; under_en = 1; load = 1; settle(1); load = 0; settle(14);
		rd(OFS_FRAME_COUNTER, 5);
		rd(OFS_LINE_UNDERRUN_COUNT, 5);
		n = 3; under_en = 0; load = 1; settle(1); load = 0; settle(10);
		rd(OFS_FRAME_COUNTER, 8);
		rd(OFS_LINE_UNDERRUN_COUNT, 5);
		rst = 1; settle(2); rst = 0;
		rd(OFS_FRAME_COUNTER, 0);
		rd(OFS_HOST_LINK_WIDTH, 0);
		complete_run;
	end
endmodule
